// [design/uart_interrupt_and_feature_control.sv]
/*
 * Interrupt enable, prioritised identification and enhanced feature
 * control for one UART channel, with auto CTS and auto RTS.
 * Assumes register strobes and all inputs are synchronous to ref_clk,
 * and that the receive FIFO level comes from the channel's FIFO.
 */
// The implementer's own choices: the register offsets and the strobed register port.
// Behaviour
// - Enable bit 4 set puts the channel into sleep mode.
// - Enable bit 3 gates the modem-status interrupt.
// - Enable bit 2 gates the receiver line-status interrupt.
// - Enable bit 1 gates the transmit-holding-empty interrupt.
// - Enable bit 0 gates the receive-data interrupt.
// - Enable bits 7:4 ignore writes unless feature bit 4 is set.
// - All enable bits, sleep included, reset to zero.
// - Identification is read-only and reports the top pending source.
// - Identification bits 7:6 both mirror the FIFO enable bit.
// - Identification bit 0 is low while an enabled source pends.
// - Identification bit 4 marks an Xoff or special character source.
// - Identification bit 5 marks a CTS or RTS low-to-high source.
// - Line error first; time-out and receive data share second.
// - Transmit empty third, modem change fourth.
// - Xoff or special character fifth, CTS/RTS change sixth.
// - With feature bit 7, a high CTS stops the transmitter.
// - With feature bit 6, RTS follows halt and resume thresholds.
// - With feature bit 5, match received characters to second Xoff.
// - Feature bit 4 gates writes to extended enable, FIFO, line bits.
// - Feature bits 3:0 select the software flow control mode.
// - Auto CTS, auto RTS and special detect reset disabled.
// - Interrupt output follows any enabled pending source.
// - Enable bits 7, 6, 5 gate CTS, RTS and Xoff sources.
`include "uart_irq_defs.svh"

`default_nettype none

module uart_interrupt_and_feature_control
    import uart_irq_pkg::*;
#(
    parameter int ADDR_W = 3,
    parameter int LEVEL_W = 7
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Register port.
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Channel events.
    input wire irq_sources_s sources,
    input wire rx_char_s rx_char,
    input wire logic xoff_received,
    input wire logic [LEVEL_W-1:0] rx_level,
    // Modem lines.
    input wire logic cts_n,
    output logic rts_n,
    // Controls to the channel.
    output logic irq,
    output logic tx_stop,
    output logic sleep_mode,
    output logic [3:0] sw_flow_mode,
    output logic [7:0] fifo_ctrl,
    output logic [7:0] line_ctrl
);

    logic [7:0] int_en;
    logic [7:0] feat;
    logic [7:0] fifo_ctl;
    logic [7:0] line_ctl;
    logic [7:0] thresh;
    logic [7:0] xoff2;
    logic xoff_flag;
    logic cts_flag;
    logic rts_flag;
    logic cts_q;
    logic rts_q;
    logic wren;
    logic id_read;
    logic special_hit;
    logic cts_rise;
    logic rts_rise;
    logic pend_lsr;
    logic pend_tmo;
    logic pend_rhr;
    logic pend_thr;
    logic pend_modem;
    logic pend_xoff;
    logic pend_flow;
    logic any_pending;
    logic [5:0] code;
    irq_src_e src;
    logic [7:0] ident;
    logic [7:0] next_rdata;
    logic [LEVEL_W-1:0] halt_level;
    logic [LEVEL_W-1:0] resume_level;

    // Write enable for extended bits and identification-read strobe.
    // Reading the identification register is what retires a sticky flag.
    assign wren = feat[`FE_WREN];
    assign id_read = rd && (addr == `OFS_INT_ID);

    // Interrupt enable register; upper nibble needs the write enable.
    // A gated write still updates the lower nibble, so the host sees no error.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            int_en <= `REG_RESET;
        end else if (wr && (addr == `OFS_INT_EN)) begin
            if (wren) begin
                int_en <= wdata;
            end else begin
                int_en <= (int_en & `IE_EXT_MASK)
                    | (wdata & ~`IE_EXT_MASK);
            end
        end
    end

    // Feature control register, always writable.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            feat <= `REG_RESET;
        end else if (wr && (addr == `OFS_FEAT)) begin
            feat <= wdata;
        end
    end

    // FIFO control register; bits 5:4 need the write enable.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fifo_ctl <= `REG_RESET;
        end else if (wr && (addr == `OFS_FIFO_CTL)) begin
            if (wren) begin
                fifo_ctl <= wdata;
            end else begin
                fifo_ctl <= (fifo_ctl & `FC_EXT_MASK)
                    | (wdata & ~`FC_EXT_MASK);
            end
        end
    end

    // Modem line control register; bits 7:5 need the write enable.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            line_ctl <= `REG_RESET;
        end else if (wr && (addr == `OFS_LINE_CTL)) begin
            if (wren) begin
                line_ctl <= wdata;
            end else begin
                line_ctl <= (line_ctl & `LC_EXT_MASK)
                    | (wdata & ~`LC_EXT_MASK);
            end
        end
    end

    // Threshold register takes writes only with both enables set.
    // Any other write to it is dropped silently.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            thresh <= `REG_RESET;
        end else if (wr && (addr == `OFS_THRESH) && wren
                && line_ctl[`LC_THRESH_EN]) begin
            thresh <= wdata;
        end
    end

    // Second Xoff character for special-character detect.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            xoff2 <= `REG_RESET;
        end else if (wr && (addr == `OFS_XOFF2)) begin
            xoff2 <= wdata;
        end
    end

    // Special character match; the character still goes to the FIFO.
    assign special_hit = feat[`FE_SPECIAL] && rx_char.valid
        && (rx_char.data == xoff2);

    // Previous pin levels for low-to-high detection.
    // Both start at the idle-high level, so leaving reset shows no false edge.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cts_q <= 1'b1;
            rts_q <= 1'b1;
        end else begin
            cts_q <= cts_n;
            rts_q <= rts_n;
        end
    end

    assign cts_rise = cts_n && !cts_q;
    assign rts_rise = rts_n && !rts_q;

    // Xoff or special flag; a new event beats a clearing read.
    // The flag latches even while its enable is clear and pends once enabled.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            xoff_flag <= 1'b0;
        end else if (xoff_received || special_hit) begin
            xoff_flag <= 1'b1;
        end else if (id_read && (src == SRC_XOFF)) begin
            xoff_flag <= 1'b0;
        end
    end

    // CTS change flag; a new edge beats a clearing read.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cts_flag <= 1'b0;
        end else if (cts_rise) begin
            cts_flag <= 1'b1;
        end else if (id_read && (src == SRC_FLOW)) begin
            cts_flag <= 1'b0;
        end
    end

    // RTS change flag; a new edge beats a clearing read.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rts_flag <= 1'b0;
        end else if (rts_rise) begin
            rts_flag <= 1'b1;
        end else if (id_read && (src == SRC_FLOW)) begin
            rts_flag <= 1'b0;
        end
    end

    // Each source gated by its enable bit.
    // Time-out and receive data share one enable, as they share one level.
    assign pend_lsr = sources.line_error && int_en[`IE_LSR];
    assign pend_tmo = sources.rx_timeout && int_en[`IE_RHR];
    assign pend_rhr = sources.rx_ready && int_en[`IE_RHR];
    assign pend_thr = sources.thr_empty && int_en[`IE_THR];
    assign pend_modem = sources.modem_change
        && int_en[`IE_MODEM];
    assign pend_xoff = xoff_flag && int_en[`IE_XOFF];
    assign pend_flow = (cts_flag && int_en[`IE_CTS])
        || (rts_flag && int_en[`IE_RTS]);

    assign any_pending = pend_lsr || pend_tmo || pend_rhr || pend_thr
        || pend_modem || pend_xoff || pend_flow;

    // Priority encoder, re-evaluated every cycle.
    // Time-out is tested before receive data inside the shared second level.
    always_comb begin
        src = SRC_NONE;
        code = `CODE_NONE;
        if (pend_lsr) begin
            src = SRC_LSR;
            code = `CODE_LSR;
        end else if (pend_tmo) begin
            src = SRC_TIMEOUT;
            code = `CODE_TIMEOUT;
        end else if (pend_rhr) begin
            src = SRC_RHR;
            code = `CODE_RHR;
        end else if (pend_thr) begin
            src = SRC_THR;
            code = `CODE_THR;
        end else if (pend_modem) begin
            src = SRC_MODEM;
            code = `CODE_MODEM;
        end else if (pend_xoff) begin
            src = SRC_XOFF;
            code = `CODE_XOFF;
        end else if (pend_flow) begin
            src = SRC_FLOW;
            code = `CODE_FLOW;
        end
    end

    // Identification byte with the FIFO enable mirrored on top.
    // Writes never reach this byte; it is rebuilt from live state.
    assign ident = {fifo_ctl[`FC_FIFO_EN], fifo_ctl[`FC_FIFO_EN],
        code};

    // Read multiplexer; identification has no write path at all.
    // The status word packs the pin and output levels into the low bits.
    always_comb begin
        next_rdata = `REG_RESET;
        if (addr == `OFS_INT_EN) begin
            next_rdata = int_en;
        end else if (addr == `OFS_INT_ID) begin
            next_rdata = ident;
        end else if (addr == `OFS_FEAT) begin
            next_rdata = feat;
        end else if (addr == `OFS_FIFO_CTL) begin
            next_rdata = fifo_ctl;
        end else if (addr == `OFS_LINE_CTL) begin
            next_rdata = line_ctl;
        end else if (addr == `OFS_THRESH) begin
            next_rdata = thresh;
        end else if (addr == `OFS_XOFF2) begin
            next_rdata = xoff2;
        end else if (addr == `OFS_STATUS) begin
            next_rdata = {5'h00, rts_n, tx_stop, irq};
        end
    end

    // Read data stand one cycle after the strobe, zero otherwise.
    // Returning zero between reads keeps a stale byte off the bus.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata <= `REG_RESET;
        end else if (rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= `REG_RESET;
        end
    end

    // Interrupt pin follows the pending set, one cycle behind.
    // The register keeps glitches of the encoder off the pin.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= any_pending;
        end
    end

    // Transmitter stop under auto CTS.
    // The stop lags the pin by one cycle, so a character may still start.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_stop <= 1'b0;
        end else begin
            tx_stop <= feat[`FE_AUTO_CTS] && cts_n;
        end
    end

    // Thresholds scaled from four-character steps.
    // Software is expected to keep the halt level above the resume level.
    assign halt_level = LEVEL_W'(thresh[3:0]) << `THRESH_SHIFT;
    assign resume_level = LEVEL_W'(thresh[7:4]) << `THRESH_SHIFT;

    // RTS pin: thresholds under auto RTS, else the line control bit.
    // Between the two levels the pin keeps its value.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rts_n <= 1'b1;
        end else if (feat[`FE_AUTO_RTS]) begin
            if (rx_level >= halt_level) begin
                rts_n <= 1'b1;
            end else if (rx_level <= resume_level) begin
                rts_n <= 1'b0;
            end
        end else begin
            rts_n <= !line_ctl[`LC_RTS];
        end
    end

    // Register copies handed to the rest of the channel.
    // Each copy runs one cycle behind the register that it mirrors.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sleep_mode <= 1'b0;
            sw_flow_mode <= 4'h0;
            fifo_ctrl <= `REG_RESET;
            line_ctrl <= `REG_RESET;
        end else begin
            sleep_mode <= int_en[`IE_SLEEP];
            sw_flow_mode <= feat[3:0];
            fifo_ctrl <= fifo_ctl;
            line_ctrl <= line_ctl;
        end
    end

endmodule

`default_nettype wire

// [design/uart_irq_defs.svh]
/*
 * Register offsets, field positions, reset values and interrupt codes
 * for one channel's interrupt and feature control.
 * Assumes a 3-bit register address and 8-bit data.
 */
`ifndef UART_IRQ_DEFS_SVH
`define UART_IRQ_DEFS_SVH

// Register offsets.
`define OFS_INT_EN 3'h0
`define OFS_INT_ID 3'h1
`define OFS_FEAT 3'h2
`define OFS_FIFO_CTL 3'h3
`define OFS_LINE_CTL 3'h4
`define OFS_THRESH 3'h5
`define OFS_XOFF2 3'h6
`define OFS_STATUS 3'h7

// Interrupt enable bit positions.
`define IE_RHR 0
`define IE_THR 1
`define IE_LSR 2
`define IE_MODEM 3
`define IE_SLEEP 4
`define IE_XOFF 5
`define IE_RTS 6
`define IE_CTS 7

// Feature control bit positions.
`define FE_WREN 4
`define FE_SPECIAL 5
`define FE_AUTO_RTS 6
`define FE_AUTO_CTS 7

// Other field positions.
`define FC_FIFO_EN 0
`define LC_RTS 1
`define LC_THRESH_EN 6

// Write masks of bits that need the write enable.
`define IE_EXT_MASK 8'hF0
`define FC_EXT_MASK 8'h30
`define LC_EXT_MASK 8'hE0

// Reset value of every register.
`define REG_RESET 8'h00

// Identification codes for bits 5:0.
`define CODE_NONE 6'h01
`define CODE_LSR 6'h06
`define CODE_TIMEOUT 6'h0C
`define CODE_RHR 6'h04
`define CODE_THR 6'h02
`define CODE_MODEM 6'h00
`define CODE_XOFF 6'h10
`define CODE_FLOW 6'h20

// Threshold fields count in steps of four characters.
`define THRESH_SHIFT 2

`endif

// [design/uart_irq_pkg.sv]
/*
 * Types for the interrupt and feature control block.
 * Assumes the defines header is compiled alongside.
 */
`default_nettype none

package uart_irq_pkg;

    // Level sources from the rest of the channel.
    typedef struct packed {
        logic line_error;
        logic rx_timeout;
        logic rx_ready;
        logic thr_empty;
        logic modem_change;
    } irq_sources_s;

    // Received character strobe with its data.
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } rx_char_s;

    // Source chosen for reporting.
    typedef enum logic [2:0] {
        SRC_NONE = 3'b000,
        SRC_LSR = 3'b001,
        SRC_TIMEOUT = 3'b010,
        SRC_RHR = 3'b011,
        SRC_THR = 3'b100,
        SRC_MODEM = 3'b101,
        SRC_XOFF = 3'b110,
        SRC_FLOW = 3'b111
    } irq_src_e;

endpackage

`default_nettype wire

// [tb/uart_irq_checker_asserts.sv]
/* Checker for the read path, interrupt output and flow outputs of one channel.
   Assumes the defines header and the package are compiled first; bound below. */
`include "uart_irq_defs.svh"
`default_nettype none
module uart_irq_checker
    import uart_irq_pkg::*;
#(
    parameter int ADDR_W = 3
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Register port.
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // Modem lines and controls.
    input wire logic cts_n,
    input wire logic rts_n,
    input wire logic irq,
    input wire logic tx_stop,
    input wire logic sleep_mode,
    input wire logic [3:0] sw_flow_mode
);
    timeunit 1ns;
    timeprecision 100ps;
    logic sleep_wr;
    logic feat_wr;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Writes that are allowed to move the sleep bit or the flow mode.
    assign sleep_wr = wr && addr == `OFS_INT_EN && wdata[`IE_SLEEP];
    assign feat_wr = wr && addr == `OFS_FEAT;
    // Reads of the identification and status registers.
    sequence ident_read;
        rd && addr == `OFS_INT_ID;
    endsequence
    sequence status_read;
        rd && addr == `OFS_STATUS;
    endsequence
    rd_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data without a read");
    id_mirror_a: assert property (ident_read |=> rdata[7] == rdata[6])
        else $error("mirror bits differ");
    id_pending_a: assert property (ident_read |=> rdata[0] == !irq)
        else $error("pending bit and irq disagree");
    id_none_a: assert property (ident_read |=> rdata[0] == (rdata[5:0] == `CODE_NONE))
        else $error("pending bit and code disagree");
    id_code_a: assert property (ident_read |=> rdata[5:0] inside {`CODE_NONE, `CODE_LSR,
            `CODE_TIMEOUT, `CODE_RHR, `CODE_THR, `CODE_MODEM, `CODE_XOFF, `CODE_FLOW})
        else $error("unknown source code");
    status_a: assert property (status_read |=>
            rdata == {5'h00, $past(rts_n), $past(tx_stop), $past(irq)})
        else $error("status read wrong");
    cts_stop_a: assert property (tx_stop |-> $past(cts_n))
        else $error("stop without high cts");
    cts_go_a: assert property (!cts_n |=> !tx_stop)
        else $error("stop while cts low");
    sleep_cause_a: assert property ($rose(sleep_mode) |-> $past(sleep_wr) || $past(sleep_wr, 2))
        else $error("sleep entered without a write");
    flow_mode_a: assert property ($changed(sw_flow_mode) |-> $past(feat_wr) || $past(feat_wr, 2))
        else $error("flow mode moved without a write");
endmodule
bind uart_interrupt_and_feature_control uart_irq_checker #(.ADDR_W(ADDR_W)) i_checker (
    .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .cts_n(cts_n), .rts_n(rts_n), .irq(irq), .tx_stop(tx_stop),
    .sleep_mode(sleep_mode), .sw_flow_mode(sw_flow_mode));
`default_nettype wire

// [tb/host_bus.sv]
/* Host processor model that drives the register port of one channel.
   Assumes the block samples strobes on the rising edge of ref_clk. */
`default_nettype none
module host_bus
    import uart_irq_pkg::*;
(
    // Clock.
    input wire logic ref_clk,
    // Register port.
    output logic [2:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    // The bus is idle from time zero.
    initial begin
        addr = 3'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    // One-cycle write strobe beside address and data.
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    // One-cycle read strobe; the data are taken at the edge closing the cycle after it.
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(posedge ref_clk);
        d = rdata;
    endtask
    // Opens the write enable first, since gated writes are otherwise lost.
    task automatic ext_write(input logic [7:0] f, input logic [2:0] a, input logic [7:0] d);
        wr_reg(3'h2, f | 8'h10);
        wr_reg(a, d);
    endtask
endmodule
`default_nettype wire

// [tb/tb_uart_interrupt_and_feature_control.sv]
/* Self-checking bench for the interrupt and feature control block.
   Assumes the package, the design, the checker and the host model are compiled first. */
`default_nettype none
module tb_uart_interrupt_and_feature_control
    import uart_irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic wr;
    logic rd;
    irq_sources_s sources = '0;
    rx_char_s rx_char = '0;
    logic xoff_received = 1'b0;
    logic [6:0] rx_level = 7'h00;
    logic cts_n = 1'b0;
    logic rts_n;
    logic irq;
    logic tx_stop;
    logic sleep_mode;
    logic [3:0] sw_flow_mode;
    logic [7:0] fifo_ctrl;
    logic [7:0] line_ctrl;
    logic [7:0] v;
    logic [7:0] e;
    integer seed = 32'hF38FB274;
    int mismatches = 0;
    int n_compared = 0;
    int ien;
    int fe;
    int fc;
    int src;
    int lvl;
    int rts;
    int rf;
    int i;
    // The clock runs at 250 MHz.
    always #2 ref_clk = ~ref_clk;
    uart_interrupt_and_feature_control i_uart_interrupt_and_feature_control (
        .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .sources(sources), .rx_char(rx_char), .xoff_received(xoff_received),
        .rx_level(rx_level), .cts_n(cts_n), .rts_n(rts_n), .irq(irq), .tx_stop(tx_stop),
        .sleep_mode(sleep_mode), .sw_flow_mode(sw_flow_mode), .fifo_ctrl(fifo_ctrl),
        .line_ctrl(line_ctrl));
    host_bus host (.ref_clk(ref_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata));
    // Counts one comparison and reports a mismatch at once.
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Reads a register and compares it with the model.
    task automatic chk(input logic [2:0] a, input logic [7:0] x);
        host.rd_reg(a, v);
        cmp(v, x);
    endtask
    // Model of the identification byte: highest enabled pending source wins.
    function automatic logic [7:0] exp_id(int en, int s, int f, int xf, int fl);
        logic [5:0] c;
        c = 6'h01;
        if (s[4] && en[2]) c = 6'h06;
        else if (s[3] && en[0]) c = 6'h0C;
        else if (s[2] && en[0]) c = 6'h04;
        else if (s[1] && en[1]) c = 6'h02;
        else if (s[0] && en[3]) c = 6'h00;
        else if (xf != 0 && en[5]) c = 6'h10;
        else if (fl != 0) c = 6'h20;
        return {f[0], f[0], c};
    endfunction
    // Prints the verdict and ends the run.
    task automatic final_report;
        if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        final_report();
    end
    // Main sequence: reset values, gated writes, random priority, flags and flow control.
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        for (i = 0; i < 4; i++) chk(i == 0 ? 3'h0 : 3'(i + 1), 8'h00);
        host.wr_reg(3'h1, 8'hFF);
        chk(3'h1, 8'h01);
        cmp({7'h00, rts_n}, 8'h01);
        host.wr_reg(3'h0, 8'hFF);
        chk(3'h0, 8'h0F);
        host.wr_reg(3'h3, 8'hFF);
        chk(3'h3, 8'hCF);
        host.wr_reg(3'h4, 8'hFD);
        chk(3'h4, 8'h1D);
        cmp(line_ctrl, 8'h1D);
        ien = 8'h0F;
        fc = 8'hCF;
        for (i = 0; i < 60; i++) begin
            src = $random(seed);
            sources <= src[4:0];
            fe = $random(seed) & 8'h1F;
            host.wr_reg(3'h2, fe[7:0]);
            v = $random(seed);
            host.wr_reg(3'h0, v);
            ien = fe[4] ? v : (ien & 8'hF0) | (v & 8'h0F);
            v = $random(seed) & 8'h3F;
            host.wr_reg(3'h3, v);
            fc = fe[4] ? v : (fc & 8'h30) | (v & 8'hCF);
            e = exp_id(ien, src, fc, 0, 0);
            chk(3'h1, e);
            cmp({7'h00, irq}, {7'h00, ~e[0]});
            chk(3'h0, ien[7:0]);
            cmp(fifo_ctrl, fc[7:0]);
            cmp({4'h0, sw_flow_mode}, {4'h0, fe[3:0]});
            cmp({7'h00, sleep_mode}, {7'h00, ien[4]});
        end
        sources <= '0;
        host.ext_write(8'h30, 3'h6, 8'h5A);
        host.wr_reg(3'h0, 8'h20);
        @(posedge ref_clk);
        xoff_received <= 1'b1;
        @(posedge ref_clk);
        xoff_received <= 1'b0;
        chk(3'h1, exp_id(32, 0, fc, 1, 0));
        chk(3'h1, exp_id(32, 0, fc, 0, 0));
        for (i = 0; i < 2; i++) begin
            @(posedge ref_clk);
            rx_char <= {1'b1, 8'h5B - i[7:0]};
            @(posedge ref_clk);
            rx_char <= '0;
            chk(3'h1, exp_id(32, 0, fc, i, 0));
        end
        host.ext_write(8'h90, 3'h0, 8'h80);
        cts_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk(3'h7, 8'h07);
        chk(3'h1, exp_id(128, 0, fc, 0, 1));
        host.wr_reg(3'h2, 8'h10);
        repeat (2) @(posedge ref_clk);
        cmp({7'h00, tx_stop}, 8'h00);
        cts_n <= 1'b0;
        host.ext_write(8'h50, 3'h4, 8'h40);
        host.wr_reg(3'h5, 8'h12);
        repeat (3) @(posedge ref_clk);
        rts = 0;
        rf = 0;
        for (i = 0; i < 30; i++) begin
            lvl = $random(seed) & 15;
            rx_level <= lvl[6:0];
            repeat (3) @(posedge ref_clk);
            if (lvl >= 8 && rts == 0) rf = 1;
            if (lvl >= 8) rts = 1;
            else if (lvl <= 4) rts = 0;
            cmp({7'h00, rts_n}, rts[7:0]);
        end
        host.wr_reg(3'h0, 8'h40);
        chk(3'h1, exp_id(64, 0, fc, 0, rf));
        chk(3'h1, exp_id(64, 0, fc, 0, 0));
        final_report();
    end
endmodule
`default_nettype wire
